// File: dspr_defines.svh
// Offsets, field positions, widths and reset values of the divider and sweep registers
`ifndef DSPR_DEFINES_SVH
`define DSPR_DEFINES_SVH
// Register indices on the address port
`define DSPR_OFS_MODE 5'h08
`define DSPR_OFS_DIV_CFG 5'h0f
`define DSPR_OFS_DWELL_HI 5'h10
`define DSPR_OFS_DWELL_LO 5'h11
`define DSPR_OFS_STEP_HI 5'h12
`define DSPR_OFS_STEP_LO 5'h13
`define DSPR_OFS_STEPDN_HI 5'h19
`define DSPR_OFS_STEPDN_LO 5'h1a
// Field widths
`define DSPR_CFG_W 15
`define DSPR_HI_W 30
`define DSPR_LO_W 18
// Divider configuration fields
`define DSPR_BIT_MOD_LONG 0
`define DSPR_BIT_PFD_LONG 1
`define DSPR_DRV_LO 2
`define DSPR_DRV_HI 4
`define DSPR_BIT_DIV_RST 5
`define DSPR_RSB_LO 6
`define DSPR_RSB_HI 8
`define DSPR_RFB_LO 9
`define DSPR_RFB_HI 11
`define DSPR_PW_LO 12
`define DSPR_PW_HI 14
// Mode register fields
`define DSPR_BIT_SWEEP_EN 11
`define DSPR_BIT_SYMM 22
// Reset values
`define DSPR_DIV_CFG_RST 15'h32ce
`define DSPR_MODE_RST 32'h0040_0000
`define DSPR_HI_RST 30'h0
`define DSPR_LO_RST 18'h0
// Pulse-width law and modulator pulse threshold
`define DSPR_PW_BASE 6'h05
`define DSPR_RATIO_THRESH 16'h0040
`endif

// File: dspr_pkg.sv
// Types shared by the divider and sweep register bank
`default_nettype none
package dspr_pkg;
   // Decoded divider controls toward the analog side
   typedef struct packed {
      logic mod_pulse_long;
      logic pfd_low_long;
      logic [2:0] drive_code;
      logic div_reset;
      logic [2:0] resync_bias;
      logic [2:0] rfbuf_bias;
      logic [5:0] pulse_cycles;
   } dspr_div_ctl_t;
   // Sweep parameters for the current direction
   typedef struct packed {
      logic active;
      logic dwell_apply;
      logic [47:0] dwell;
      logic [47:0] step;
   } dspr_sweep_t;
endpackage : dspr_pkg
`default_nettype wire

// File: dspr_div_ctl.sv
// Divider configuration decode toward the analog divider
`timescale 1ns/10ps
`default_nettype none
`include "dspr_defines.svh"
module dspr_div_ctl (
   input wire logic clk_sys,
   input wire logic rst_n_sync,
   input wire logic [14:0] cfg,
   input wire logic [15:0] div_ratio,
   output dspr_pkg::dspr_div_ctl_t ctl_reg
);
   import dspr_pkg::*;
   dspr_div_ctl_t ctl_next;
   // Field decode; biases pass through untouched
   always_comb begin
      ctl_next = '0;
      ctl_next.mod_pulse_long = cfg[`DSPR_BIT_MOD_LONG] &&
         (div_ratio > `DSPR_RATIO_THRESH);
      ctl_next.pfd_low_long = cfg[`DSPR_BIT_PFD_LONG];
      ctl_next.drive_code = cfg[`DSPR_DRV_HI:`DSPR_DRV_LO];
      ctl_next.div_reset = cfg[`DSPR_BIT_DIV_RST];
      ctl_next.resync_bias = cfg[`DSPR_RSB_HI:`DSPR_RSB_LO];
      ctl_next.rfbuf_bias = cfg[`DSPR_RFB_HI:`DSPR_RFB_LO];
      ctl_next.pulse_cycles = {cfg[`DSPR_PW_HI:`DSPR_PW_LO], 3'h0}
         + `DSPR_PW_BASE;
   end
   // Registered so analog controls never glitch
   always_ff @(posedge clk_sys or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ctl_reg <= '0;
      end else begin
         ctl_reg <= ctl_next;
      end
   end
endmodule : dspr_div_ctl
`default_nettype wire

// File: dspr_sweep_sel.sv
// Direction-dependent sweep dwell and step selection
`timescale 1ns/10ps
`default_nettype none
`include "dspr_defines.svh"
module dspr_sweep_sel (
   input wire logic clk_sys,
   input wire logic rst_n_sync,
   input wire logic sweep_en,
   input wire logic symm,
   input wire logic dir_up,
   input wire logic [29:0] dwell_hi,
   input wire logic [17:0] dwell_lo,
   input wire logic [29:0] step_hi,
   input wire logic [17:0] step_lo,
   input wire logic [29:0] stepdn_hi,
   input wire logic [17:0] stepdn_lo,
   output dspr_pkg::dspr_sweep_t sweep_reg
);
   import dspr_pkg::*;
   dspr_sweep_t sweep_next;
   logic use_up;
   // Up parameters serve both ways only when symmetric
   assign use_up = symm || dir_up;
   always_comb begin
      sweep_next = '0;
      sweep_next.active = sweep_en;
      if (sweep_en) begin
         sweep_next.dwell_apply = use_up;
         sweep_next.dwell = use_up ? {dwell_hi, dwell_lo} : 48'h0;
         sweep_next.step = use_up ? {step_hi, step_lo}
            : {stepdn_hi, stepdn_lo};
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         sweep_reg <= '0;
      end else begin
         sweep_reg <= sweep_next;
      end
   end
endmodule : dspr_sweep_sel
`default_nettype wire

// File: dspr_regs.sv
// Divider pulse/drive and sweep dwell/step register bank, top level
//
// Summary of operation
// - Bit 0 lengthens modulator pulse above ratio 64
// - Bit 1, default set, lengthens detector clock low
// - Bits 4:2 drive code, default 011, forwarded
// - Bit 5 holds RF divider in reset
// - Bits 14:12 give pulse 5 plus 8*code cycles
// - Dwell: 30-bit upper, 18-bit lower, reset zero
// - Dwell both ways symmetric, up only asymmetric
// - Step: 30-bit upper, 18-bit lower, reset zero
// - Step both ways symmetric, up only asymmetric
// - Symmetric bit, default set; else separate down
// - Sweep enable bit, default clear, activates parameters
// - Asymmetric down step from dedicated register pair
`timescale 1ns/10ps
`default_nettype none
`include "dspr_defines.svh"
module dspr_regs (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [4:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] div_ratio,
   input wire logic sweep_dir_up,
   output logic [31:0] rdata,
   output dspr_pkg::dspr_div_ctl_t div_ctl,
   output dspr_pkg::dspr_sweep_t sweep
);
   import dspr_pkg::*;

   logic rst_meta_reg;
   logic rst_n_sync;
   logic [14:0] div_cfg_reg;
   logic [31:0] mode_reg;
   logic [29:0] dwell_hi_reg;
   logic [17:0] dwell_lo_reg;
   logic [29:0] step_hi_reg;
   logic [17:0] step_lo_reg;
   logic [29:0] stepdn_hi_reg;
   logic [17:0] stepdn_lo_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_sync <= rst_meta_reg;
      end
   end

   // Divider configuration register, only 15 bits stored
   always_ff @(posedge clk_sys or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         div_cfg_reg <= `DSPR_DIV_CFG_RST;
      end else if (wr && addr == `DSPR_OFS_DIV_CFG) begin
         div_cfg_reg <= wdata[14:0];
      end
   end

   // Mode register: sweep enable and symmetric selection
   always_ff @(posedge clk_sys or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         mode_reg <= `DSPR_MODE_RST;
      end else if (wr && addr == `DSPR_OFS_MODE) begin
         mode_reg <= wdata;
      end
   end

   // Dwell pair, upper and lower written independently
   always_ff @(posedge clk_sys or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         dwell_hi_reg <= `DSPR_HI_RST;
         dwell_lo_reg <= `DSPR_LO_RST;
      end else if (wr) begin
         if (addr == `DSPR_OFS_DWELL_HI) begin
            dwell_hi_reg <= wdata[29:0];
         end else if (addr == `DSPR_OFS_DWELL_LO) begin
            dwell_lo_reg <= wdata[17:0];
         end
      end
   end

   // Step pairs for up/symmetric and dedicated down
   always_ff @(posedge clk_sys or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         step_hi_reg <= `DSPR_HI_RST;
         step_lo_reg <= `DSPR_LO_RST;
         stepdn_hi_reg <= `DSPR_HI_RST;
         stepdn_lo_reg <= `DSPR_LO_RST;
      end else if (wr) begin
         if (addr == `DSPR_OFS_STEP_HI) begin
            step_hi_reg <= wdata[29:0];
         end else if (addr == `DSPR_OFS_STEP_LO) begin
            step_lo_reg <= wdata[17:0];
         end else if (addr == `DSPR_OFS_STEPDN_HI) begin
            stepdn_hi_reg <= wdata[29:0];
         end else if (addr == `DSPR_OFS_STEPDN_LO) begin
            stepdn_lo_reg <= wdata[17:0];
         end
      end
   end

   // Read mux; unused bits and unmapped indices read zero
   always_comb begin
      rdata_next = 32'h0;
      if (!rd) begin
         rdata_next = 32'h0;
      end else if (addr == `DSPR_OFS_DIV_CFG) begin
         rdata_next = {17'h0, div_cfg_reg};
      end else if (addr == `DSPR_OFS_MODE) begin
         rdata_next = mode_reg;
      end else if (addr == `DSPR_OFS_DWELL_HI) begin
         rdata_next = {2'h0, dwell_hi_reg};
      end else if (addr == `DSPR_OFS_DWELL_LO) begin
         rdata_next = {14'h0, dwell_lo_reg};
      end else if (addr == `DSPR_OFS_STEP_HI) begin
         rdata_next = {2'h0, step_hi_reg};
      end else if (addr == `DSPR_OFS_STEP_LO) begin
         rdata_next = {14'h0, step_lo_reg};
      end else if (addr == `DSPR_OFS_STEPDN_HI) begin
         rdata_next = {2'h0, stepdn_hi_reg};
      end else if (addr == `DSPR_OFS_STEPDN_LO) begin
         rdata_next = {14'h0, stepdn_lo_reg};
      end
   end

   // Read data stand for one cycle only, zero otherwise
   always_ff @(posedge clk_sys or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign rdata = rdata_reg;

   // Divider decode; one cycle behind the register
   dspr_div_ctl u_div_ctl (
      .clk_sys(clk_sys),
      .rst_n_sync(rst_n_sync),
      .cfg(div_cfg_reg),
      .div_ratio(div_ratio),
      .ctl_reg(div_ctl)
   );

   // Sweep selection; direction comes from the sweep engine
   dspr_sweep_sel u_sweep_sel (
      .clk_sys(clk_sys),
      .rst_n_sync(rst_n_sync),
      .sweep_en(mode_reg[`DSPR_BIT_SWEEP_EN]),
      .symm(mode_reg[`DSPR_BIT_SYMM]),
      .dir_up(sweep_dir_up),
      .dwell_hi(dwell_hi_reg),
      .dwell_lo(dwell_lo_reg),
      .step_hi(step_hi_reg),
      .step_lo(step_lo_reg),
      .stepdn_hi(stepdn_hi_reg),
      .stepdn_lo(stepdn_lo_reg),
      .sweep_reg(sweep)
   );

   // Checks: all on clk_sys, quiet while reset is held
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n_sync);

   cfg_write_a: assert property (
      wr && addr == `DSPR_OFS_DIV_CFG |=> div_cfg_reg == $past(wdata[14:0]))
      else $error("divider config write not stored");

   dwell_read_a: assert property (
      wr && addr == `DSPR_OFS_DWELL_HI ##1 rd && addr == `DSPR_OFS_DWELL_HI
      |=> rdata == {2'h0, $past(wdata[29:0], 2)})
      else $error("dwell upper read back wrong");

   read_idle_a: assert property (
      !rd |=> rdata == 32'h0)
      else $error("read data outside read cycle");

   mod_pulse_a: assert property (
      wr && addr == `DSPR_OFS_DIV_CFG && wdata[0] && div_ratio <= 16'h0040
      ##1 $stable(div_ratio) |=> !div_ctl.mod_pulse_long)
      else $error("modulator pulse lengthened at low ratio");

   pfd_drive_a: assert property (
      $past(rst_n_sync) |-> div_ctl.pfd_low_long == $past(div_cfg_reg[1]) &&
      div_ctl.drive_code == $past(div_cfg_reg[4:2]) &&
      div_ctl.div_reset == $past(div_cfg_reg[5]))
      else $error("divider controls do not track config");

   pulse_width_a: assert property (
      wr && addr == `DSPR_OFS_DIV_CFG ##1 !wr
      |=> div_ctl.pulse_cycles == 6'h05 + 6'(8 * $past(wdata[14:12], 2)))
      else $error("pulse width law broken");

   sym_step_a: assert property (
      mode_reg[22] && mode_reg[11]
      |=> sweep.step == $past({step_hi_reg, step_lo_reg}) && sweep.dwell_apply)
      else $error("symmetric step wrong");

   asym_down_a: assert property (
      !mode_reg[22] && mode_reg[11] && !sweep_dir_up
      |=> sweep.step == $past({stepdn_hi_reg, stepdn_lo_reg}) && !sweep.dwell_apply)
      else $error("asymmetric down parameters wrong");

   asym_up_a: assert property (
      !mode_reg[22] && mode_reg[11] && sweep_dir_up
      |=> sweep.dwell == $past({dwell_hi_reg, dwell_lo_reg}))
      else $error("asymmetric up dwell wrong");

   sweep_off_a: assert property (
      !mode_reg[11] |=> !sweep.active && sweep.step == 48'h0)
      else $error("parameters active outside sweep mode");

   step_reset_a: assert property (
      $rose(rst_n_sync) |-> step_lo_reg == 18'h0 && step_hi_reg == 30'h0)
      else $error("step registers not cleared by reset");

   // Reset defaults of the stored fields other than the up/symmetric step pair
   cfg_reset_a: assert property (
      $rose(rst_n_sync) |-> div_cfg_reg == `DSPR_DIV_CFG_RST && mode_reg == `DSPR_MODE_RST)
      else $error("config or mode default wrong after reset");

   dwell_reset_a: assert property (
      $rose(rst_n_sync) |-> dwell_hi_reg == 30'h0 && dwell_lo_reg == 18'h0)
      else $error("dwell registers not cleared by reset");

   down_reset_a: assert property (
      $rose(rst_n_sync) |-> stepdn_hi_reg == 30'h0 && stepdn_lo_reg == 18'h0)
      else $error("down step registers not cleared by reset");

   // Write capture of one half of each register pair
   dwell_write_a: assert property (
      wr && addr == `DSPR_OFS_DWELL_LO |=> dwell_lo_reg == $past(wdata[17:0]))
      else $error("dwell lower write not stored");

   step_write_a: assert property (
      wr && addr == `DSPR_OFS_STEP_HI |=> step_hi_reg == $past(wdata[29:0]))
      else $error("step upper write not stored");

   down_write_a: assert property (
      wr && addr == `DSPR_OFS_STEPDN_LO |=> stepdn_lo_reg == $past(wdata[17:0]))
      else $error("down step lower write not stored");

   // Read-back paths, one cycle after the strobe
   mode_read_a: assert property (
      rd && addr == `DSPR_OFS_MODE |=> rdata == $past(mode_reg))
      else $error("mode read back wrong");

   cfg_read_a: assert property (
      rd && addr == `DSPR_OFS_DIV_CFG |=> rdata == {17'h0, $past(div_cfg_reg)})
      else $error("divider config read back wrong");

   step_read_a: assert property (
      rd && addr == `DSPR_OFS_STEP_LO |=> rdata == {14'h0, $past(step_lo_reg)})
      else $error("step lower read back wrong");

   unmapped_read_a: assert property (
      rd && addr == 5'h00 |=> rdata == 32'h0)
      else $error("unmapped index reads nonzero");

   // Divider decode beyond the basic controls
   mod_long_a: assert property (
      wr && addr == `DSPR_OFS_DIV_CFG && wdata[0] && div_ratio > 16'h0040
      ##1 $stable(div_ratio) |=> div_ctl.mod_pulse_long)
      else $error("modulator pulse not lengthened at high ratio");

   bias_fwd_a: assert property (
      $past(rst_n_sync) |-> div_ctl.resync_bias == $past(div_cfg_reg[8:6]) &&
      div_ctl.rfbuf_bias == $past(div_cfg_reg[11:9]))
      else $error("bias codes not forwarded");

   // Sweep selection beyond the basic cases
   sweep_on_a: assert property (
      mode_reg[11] |=> sweep.active)
      else $error("sweep parameters inactive in sweep mode");

   sym_dwell_a: assert property (
      mode_reg[22] && mode_reg[11] |=> sweep.dwell == $past({dwell_hi_reg, dwell_lo_reg}))
      else $error("symmetric dwell wrong");

   asym_step_a: assert property (
      !mode_reg[22] && mode_reg[11] && sweep_dir_up
      |=> sweep.step == $past({step_hi_reg, step_lo_reg}) && sweep.dwell_apply)
      else $error("asymmetric up step wrong");

   // Main scenarios the tests should reach
   cfg_write_c: cover property (wr && addr == `DSPR_OFS_DIV_CFG);
   asym_down_c: cover property (!mode_reg[22] && mode_reg[11] && !sweep_dir_up);
   long_pulse_c: cover property (div_ctl.mod_pulse_long);
   step_read_c: cover property (rd && addr == `DSPR_OFS_STEP_LO);
   sym_sweep_c: cover property (mode_reg[22] && mode_reg[11]);

endmodule : dspr_regs
`default_nettype wire

// File: dspr_far_side.sv
// Stand-in for the ratio source and sweep engine beside the register bank
`timescale 1ns/10ps
`default_nettype none
module dspr_far_side (
   input wire logic clk_sys,
   input wire logic [15:0] ratio_set,
   input wire logic up_set,
   output logic [15:0] div_ratio,
   output logic sweep_dir_up
);
   // Registered, as same-clock logic would present them
   always_ff @(posedge clk_sys) begin
      div_ratio <= ratio_set;
      sweep_dir_up <= up_set;
   end
endmodule : dspr_far_side
`default_nettype wire

// File: test_divider_and_sweep_param_regs.sv
// Self-checking bench for the divider and sweep register bank
`timescale 1ns/10ps
`default_nettype none
module test_divider_and_sweep_param_regs;
   import dspr_pkg::*;
   logic clk_sys, rstn, wr, rd, up_set, rd_q, sweep_dir_up;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, seed, v;
   logic [31:0] mdl [0:31];
   logic [15:0] ratio_set, div_ratio;
   logic [4:0] halves [0:7] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h19, 5'h1a, 5'h11, 5'h1a};
   dspr_div_ctl_t div_ctl;
   dspr_sweep_t sweep;
   logic [31:0] exp_q [$];
   int n_mismatch, checks_done;

   dspr_regs i_dspr_regs (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .div_ratio(div_ratio), .sweep_dir_up(sweep_dir_up),
      .rdata(rdata), .div_ctl(div_ctl), .sweep(sweep));
   dspr_far_side i_dspr_far_side (.clk_sys(clk_sys), .ratio_set(ratio_set),
      .up_set(up_set), .div_ratio(div_ratio), .sweep_dir_up(sweep_dir_up));

   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Stored bits of each index; unmapped ones keep nothing
   function automatic logic [31:0] msk(input logic [4:0] a);
      case (a)
         5'h08: return 32'hffff_ffff;
         5'h0f: return 32'h0000_7fff;
         5'h10, 5'h12, 5'h19: return 32'h3fff_ffff;
         5'h11, 5'h13, 5'h1a: return 32'h0003_ffff;
         default: return 32'h0;
      endcase
   endfunction : msk

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   function automatic dspr_div_ctl_t exp_div(input logic [14:0] c, input logic [15:0] r);
      return {c[0] && (r > 16'h0040), c[1], c[4:2], c[5], c[8:6], c[11:9],
         6'h05 + {c[14:12], 3'h0}};
   endfunction : exp_div

   // Down direction in asymmetric mode has no dwell here
   function automatic dspr_sweep_t exp_sw(input logic up);
      logic u;
      u = mdl[5'h08][22] || up;
      if (!mdl[5'h08][11]) return '0;
      return {1'b1, u, u ? {mdl[5'h10][29:0], mdl[5'h11][17:0]} : 48'h0,
         u ? {mdl[5'h12][29:0], mdl[5'h13][17:0]} : {mdl[5'h19][29:0], mdl[5'h1a][17:0]}};
   endfunction : exp_sw

   // One bus cycle; strobes stay as set until the next call
   task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      if (w) mdl[a] = d & msk(a);
      if (r) exp_q.push_back(mdl[a]);
   endtask : op

   task automatic settle();
      op(1'b0, 1'b0, 5'h00, 32'h0);
      @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : settle

   task automatic do_reset();
      for (int a = 0; a < 32; a++) mdl[a] = 32'h0;
      mdl[5'h08] = 32'h0040_0000;
      mdl[5'h0f] = 32'h0000_32ce;
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(div_ctl, '0);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
   endtask : do_reset

   task automatic defaults(input string nm);
      for (int a = 0; a < 32; a++) op(1'b0, 1'b1, a[4:0], 32'h0);
      settle();
      chk(div_ctl, exp_div(15'h32ce, ratio_set));
      chk(sweep, '0);
      $display("test %s done", nm);
   endtask : defaults

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   // Read data is valid only in the cycle after the strobe edge
   always @(posedge clk_sys) begin
      rd_q <= rd;
      if (rd_q === 1'b1) chk(rdata, exp_q.pop_front());
   end

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #(5000 * 100);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 5'h00;
      wdata = 32'h0;
      seed = 32'h2766_1d93;
      ratio_set = 16'h0000;
      up_set = 1'b0;
      do_reset();
      defaults("reset");
      // Every index written back to back, unmapped ones too
      for (int a = 0; a < 32; a++) begin
         v = rnd();
         if (a == 15) v[11:6] = 6'b001_011;
         op(1'b1, 1'b0, a[4:0], v);
      end
      for (int a = 0; a < 32; a++) op(1'b0, 1'b1, a[4:0], 32'h0);
      settle();
      $display("test fill done");
      // Each pulse-width code while the ratio walks across the threshold
      for (int c = 0; c < 8; c++) begin
         v = rnd();
         v[14:12] = c[2:0];
         v[11:6] = 6'b001_011;
         v[0] = 1'b1;
         ratio_set = 16'h003f + c[15:0];
         op(1'b1, 1'b0, 5'h0f, v);
         settle();
         chk(div_ctl, exp_div(v[14:0], ratio_set));
      end
      $display("test divider done");
      // Enable, symmetry and direction in all combinations, one half rewritten
      for (int i = 0; i < 8; i++) begin
         v = rnd();
         v[11] = i[0];
         v[22] = i[1];
         up_set = i[2];
         op(1'b1, 1'b0, 5'h08, v);
         op(1'b1, 1'b0, halves[i], rnd());
         // Read straight back so the write-then-read path is exercised
         op(1'b0, 1'b1, halves[i], 32'h0);
         settle();
         chk(sweep, exp_sw(up_set));
      end
      $display("test sweep done");
      do_reset();
      defaults("midrun reset");
      wrap_up();
   end
endmodule : test_divider_and_sweep_param_regs
`default_nettype wire
